// >>> design/smia_aggregator.sv
// SMI status/enable aggregator with APB register slave
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none

module smia_aggregator
(
  // Clock and standby power-on reset
  input  wire logic                   ref_clk,
  input  wire logic                   rst_b,
  // APB slave
  input  wire smia_pkg::smia_apb_req_s apbReq,
  output smia_pkg::smia_apb_rsp_s      apbRsp,
  // Interrupt sources
  input  wire smia_pkg::smia_dev_src_s devSrc,
  input  wire logic                   infraredRx,
  input  wire logic [7:0]             pinEventsA,
  input  wire logic [7:0]             pinEventsB,
  input  wire logic [7:0]             pinEventsFan,
  // Group outputs
  output logic                        groupMgmtInterrupt,
  output logic                        mgmtInterruptOutN,
  output logic                        groupToSerialIrq,
  output logic                        groupToWakeLogic
);
  import smia_pkg::*;

  // Registers
  logic [7:0] enDevA_reg;
  logic [7:0] enDevB_reg;
  logic [7:0] enPinsA_reg;
  logic [7:0] enPinsB_reg;
  logic [7:0] enPinsFan_reg;
  logic [7:0] stsPinsA_reg;
  logic [7:0] stsPinsB_reg;
  logic [7:0] stsPinsFan_reg;
  logic       irFlag_reg;
  logic [7:0] rdData_reg;
  logic [2:0] irSync_reg;
  logic       irStable_reg;
  logic [7:0] pinsASync1_reg;
  logic [7:0] pinsASync2_reg;
  logic [7:0] pinsASync3_reg;
  logic [7:0] pinsBSync1_reg;
  logic [7:0] pinsBSync2_reg;
  logic [7:0] pinsBSync3_reg;
  logic [7:0] fanSync1_reg;
  logic [7:0] fanSync2_reg;
  logic [7:0] fanSync3_reg;
  logic [7:0] pinsAStable_reg;
  logic [7:0] pinsBStable_reg;
  logic [7:0] fanStable_reg;
  logic [8:0] devSync1_reg;
  logic [8:0] devSync2_reg;
  logic [8:0] devSync3_reg;
  logic [8:0] devStable_reg;

  // Next values
  logic [7:0] stsPinsA_next;
  logic [7:0] stsPinsB_next;
  logic [7:0] stsPinsFan_next;
  logic       irFlag_next;
  logic [7:0] rdData_next;

  // Bus decode wires
  wire        accessPhase;
  wire        wrStrobe;
  wire        rdStrobe;
  wire        wordAligned;
  wire [5:0]  regIndex;
  wire [7:0]  wrByte;
  wire        mapped;

  // Event wires
  wire        irEdge;
  wire [7:0]  pinsARise;
  wire [7:0]  pinsBRise;
  wire [7:0]  fanRise;
  wire [7:0]  pinsAAgreed;
  wire [7:0]  pinsBAgreed;
  wire [7:0]  fanAgreed;
  wire [7:0]  stsDevA;
  wire [7:0]  stsDevB;

  // Hit decoder: strobe qualified by register index
  function automatic logic hit(input logic [5:0] idx,
                               input logic [7:0] target,
                               input logic       strobe);
    hit = strobe && ({2'b00, idx} == target);
  endfunction

  // Write-one-clear with set winning over clear
  function automatic logic [7:0] w1c(input logic [7:0] cur,
                                     input logic [7:0] setBits,
                                     input logic [7:0] clrBits,
                                     input logic [7:0] mask);
    w1c = ((cur & ~clrBits) | setBits) & mask;
  endfunction

  // Agreed level: moves only once stages two and three match
  function automatic logic [7:0] agree8(input logic [7:0] s2,
                                        input logic [7:0] s3,
                                        input logic [7:0] held);
    agree8 = (s2 & s3) | (held & (s2 | s3));
  endfunction

  // APB decode; zero wait states
  assign accessPhase = apbReq.psel && apbReq.penable;
  assign wordAligned = (apbReq.paddr[1:0] == 2'b00);
  assign regIndex    = apbReq.paddr[7:2];
  assign wrStrobe    = accessPhase && apbReq.pwrite && wordAligned;
  // Read strobe marks the setup cycle, when the read word is captured
  assign rdStrobe    = apbReq.psel && !apbReq.penable && !apbReq.pwrite
                       && wordAligned;
  assign wrByte      = apbReq.pwdata[7:0];
  assign mapped      = wordAligned && ({2'b00, regIndex} >= IDX_STS_DEV_A)
                       && ({2'b00, regIndex} <= IDX_GAP_B);

  // Response: always ready, error for unmapped addresses
  assign apbRsp.pready  = 1'b1;
  assign apbRsp.pslverr = accessPhase && !mapped;
  assign apbRsp.prdata  = {24'h000000, rdData_reg};

  // Status composition for device sources
  assign stsDevA = {devStable_reg[3], 1'b0, devStable_reg[4],
                    devStable_reg[5], devStable_reg[6],
                    devStable_reg[7], devStable_reg[8], 1'b0};
  assign stsDevB = {3'b000, devStable_reg[0], 1'b0, irFlag_reg,
                    devStable_reg[1], devStable_reg[2]};

  // Edge detection on agreed synchroniser stages
  assign irEdge    = (irSync_reg[2] == irSync_reg[1])
                     && (irSync_reg[1] != irStable_reg);
  // Agreed pin levels; a single-stage glitch never counts
  assign pinsAAgreed = agree8(pinsASync2_reg, pinsASync3_reg,
                              pinsAStable_reg);
  assign pinsBAgreed = agree8(pinsBSync2_reg, pinsBSync3_reg,
                              pinsBStable_reg);
  assign fanAgreed   = agree8(fanSync2_reg, fanSync3_reg,
                              fanStable_reg);
  // One-cycle rise pulses from the agreed levels
  assign pinsARise = pinsAAgreed & ~pinsAStable_reg;
  assign pinsBRise = pinsBAgreed & ~pinsBStable_reg;
  assign fanRise   = fanAgreed & ~fanStable_reg;

  // Status next values
  always_comb
  begin
    stsPinsA_next   = w1c(stsPinsA_reg, pinsARise,
                          hit(regIndex, IDX_STS_PINS_A, wrStrobe)
                          ? wrByte : 8'h00, MASK_PINS_A);
    stsPinsB_next   = w1c(stsPinsB_reg, pinsBRise,
                          hit(regIndex, IDX_STS_PINS_B, wrStrobe)
                          ? wrByte : 8'h00, MASK_PINS_B);
    stsPinsFan_next = w1c(stsPinsFan_reg, fanRise,
                          hit(regIndex, IDX_STS_PINS_FAN, wrStrobe)
                          ? wrByte : 8'h00, MASK_PINS_FAN);
    irFlag_next     = irFlag_reg;
    // Clear as the read word is captured, so a same-cycle edge wins
    if (hit(regIndex, IDX_STS_DEV_B, rdStrobe))
    begin
      irFlag_next = 1'b0;
    end
    if (irEdge)
    begin
      irFlag_next = 1'b1;
    end
  end

  // Read data mux; reserved locations return zero
  always_comb
  begin
    case ({2'b00, regIndex})
      IDX_STS_DEV_A:    rdData_next = stsDevA;
      IDX_STS_DEV_B:    rdData_next = stsDevB;
      IDX_STS_PINS_A:   rdData_next = stsPinsA_reg;
      IDX_STS_PINS_B:   rdData_next = stsPinsB_reg;
      IDX_STS_PINS_FAN: rdData_next = stsPinsFan_reg;
      IDX_EN_DEV_A:     rdData_next = enDevA_reg;
      IDX_EN_DEV_B:     rdData_next = enDevB_reg;
      IDX_EN_PINS_A:    rdData_next = enPinsA_reg;
      IDX_EN_PINS_B:    rdData_next = enPinsB_reg;
      IDX_EN_PINS_FAN:  rdData_next = enPinsFan_reg;
      default:          rdData_next = RESET_VALUE;
    endcase
    if (!rdStrobe)
    begin
      rdData_next = rdData_reg;
    end
  end

  // Infrared synchroniser, three stages, and its agreed level
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      irSync_reg   <= 3'b000;
      irStable_reg <= 1'b0;
    end
    else
    begin
      irSync_reg <= {irSync_reg[1:0], infraredRx};
      if (irSync_reg[2] == irSync_reg[1])
      begin
        irStable_reg <= irSync_reg[1];
      end
    end
  end

  // Pin group A synchroniser and agreed level
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pinsASync1_reg  <= RESET_VALUE;
      pinsASync2_reg  <= RESET_VALUE;
      pinsASync3_reg  <= RESET_VALUE;
      pinsAStable_reg <= RESET_VALUE;
    end
    else
    begin
      pinsASync1_reg  <= pinEventsA;
      pinsASync2_reg  <= pinsASync1_reg;
      pinsASync3_reg  <= pinsASync2_reg;
      pinsAStable_reg <= pinsAAgreed;
    end
  end

  // Pin group B synchroniser and agreed level
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pinsBSync1_reg  <= RESET_VALUE;
      pinsBSync2_reg  <= RESET_VALUE;
      pinsBSync3_reg  <= RESET_VALUE;
      pinsBStable_reg <= RESET_VALUE;
    end
    else
    begin
      pinsBSync1_reg  <= pinEventsB;
      pinsBSync2_reg  <= pinsBSync1_reg;
      pinsBSync3_reg  <= pinsBSync2_reg;
      pinsBStable_reg <= pinsBAgreed;
    end
  end

  // Pin and tachometer group synchroniser and agreed level
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      fanSync1_reg  <= RESET_VALUE;
      fanSync2_reg  <= RESET_VALUE;
      fanSync3_reg  <= RESET_VALUE;
      fanStable_reg <= RESET_VALUE;
    end
    else
    begin
      fanSync1_reg  <= pinEventsFan;
      fanSync2_reg  <= fanSync1_reg;
      fanSync3_reg  <= fanSync2_reg;
      fanStable_reg <= fanAgreed;
    end
  end

  // Device source synchroniser; level moves once stages agree
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      devSync1_reg  <= 9'h000;
      devSync2_reg  <= 9'h000;
      devSync3_reg  <= 9'h000;
      devStable_reg <= 9'h000;
    end
    else
    begin
      devSync1_reg  <= devSrc;
      devSync2_reg  <= devSync1_reg;
      devSync3_reg  <= devSync2_reg;
      devStable_reg <= (devSync2_reg & devSync3_reg)
                       | (devStable_reg & (devSync2_reg | devSync3_reg));
    end
  end

  // Enable registers, reserved bits masked
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      enDevA_reg    <= RESET_VALUE;
      enDevB_reg    <= RESET_VALUE;
      enPinsA_reg   <= RESET_VALUE;
      enPinsB_reg   <= RESET_VALUE;
      enPinsFan_reg <= RESET_VALUE;
    end
    else
    begin
      if (hit(regIndex, IDX_EN_DEV_A, wrStrobe))
      begin
        enDevA_reg <= wrByte & MASK_DEV_A;
      end
      if (hit(regIndex, IDX_EN_DEV_B, wrStrobe))
      begin
        enDevB_reg <= wrByte & MASK_DEV_B_EN;
      end
      if (hit(regIndex, IDX_EN_PINS_A, wrStrobe))
      begin
        enPinsA_reg <= wrByte & MASK_PINS_A;
      end
      if (hit(regIndex, IDX_EN_PINS_B, wrStrobe))
      begin
        enPinsB_reg <= wrByte & MASK_PINS_B;
      end
      if (hit(regIndex, IDX_EN_PINS_FAN, wrStrobe))
      begin
        enPinsFan_reg <= wrByte & MASK_PINS_FAN;
      end
    end
  end

  // Status registers and read data
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      stsPinsA_reg   <= RESET_VALUE;
      stsPinsB_reg   <= RESET_VALUE;
      stsPinsFan_reg <= RESET_VALUE;
      irFlag_reg     <= 1'b0;
      rdData_reg     <= RESET_VALUE;
    end
    else
    begin
      stsPinsA_reg   <= stsPinsA_next;
      stsPinsB_reg   <= stsPinsB_next;
      stsPinsFan_reg <= stsPinsFan_next;
      irFlag_reg     <= irFlag_next;
      rdData_reg     <= rdData_next;
    end
  end

  // Group SMI and its three routes
  assign groupMgmtInterrupt = |(stsDevA & enDevA_reg & MASK_DEV_A)
    | |(stsDevB & enDevB_reg & MASK_DEV_B_SRC)
    | |(stsPinsA_reg & enPinsA_reg)
    | |(stsPinsB_reg & enPinsB_reg)
    | |(stsPinsFan_reg & enPinsFan_reg);
  assign groupToWakeLogic  = groupMgmtInterrupt
                             && enDevB_reg[BIT_ROUTE_WAKE];
  assign groupToSerialIrq  = groupMgmtInterrupt
                             && enDevB_reg[BIT_ROUTE_SIRQ];
  assign mgmtInterruptOutN = !(groupMgmtInterrupt
                             && enDevB_reg[BIT_ROUTE_PIN]);

endmodule

`default_nettype wire

// >>> inc/smia_pkg.sv
// Package: register map, field positions and carrier types for SMI aggregator
`default_nettype none
package smia_pkg;

  // Register indices as printed; byte address is four times the index
  localparam logic [7:0] IDX_STS_DEV_A    = 8'h10;
  localparam logic [7:0] IDX_STS_DEV_B    = 8'h11;
  localparam logic [7:0] IDX_STS_PINS_A   = 8'h12;
  localparam logic [7:0] IDX_STS_PINS_B   = 8'h13;
  localparam logic [7:0] IDX_STS_PINS_FAN = 8'h14;
  localparam logic [7:0] IDX_GAP_A        = 8'h15;
  localparam logic [7:0] IDX_EN_DEV_A     = 8'h16;
  localparam logic [7:0] IDX_EN_DEV_B     = 8'h17;
  localparam logic [7:0] IDX_EN_PINS_A    = 8'h18;
  localparam logic [7:0] IDX_EN_PINS_B    = 8'h19;
  localparam logic [7:0] IDX_EN_PINS_FAN  = 8'h1A;
  localparam logic [7:0] IDX_GAP_B        = 8'h1B;

  // Writable or valid bit masks per register
  localparam logic [7:0] MASK_DEV_A       = 8'hBE;
  localparam logic [7:0] MASK_DEV_B_SRC   = 8'h17;
  localparam logic [7:0] MASK_DEV_B_EN    = 8'hF7;
  localparam logic [7:0] MASK_PINS_A      = 8'hF7;
  localparam logic [7:0] MASK_PINS_B      = 8'hFF;
  localparam logic [7:0] MASK_PINS_FAN    = 8'hCF;

  // Field positions in the second status and enable registers
  localparam int unsigned BIT_MOUSE       = 0;
  localparam int unsigned BIT_KEYBOARD    = 1;
  localparam int unsigned BIT_INFRARED    = 2;
  localparam int unsigned BIT_KBD_PORT    = 4;
  localparam int unsigned BIT_ROUTE_WAKE  = 5;
  localparam int unsigned BIT_ROUTE_SIRQ  = 6;
  localparam int unsigned BIT_ROUTE_PIN   = 7;

  // Reset value of every register
  localparam logic [7:0] RESET_VALUE      = 8'h00;

  // Bus widths
  localparam int unsigned ADDR_W          = 8;
  localparam int unsigned DATA_W          = 32;

  // APB request carrier
  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
  } smia_apb_req_s;

  // APB response carrier
  typedef struct packed {
    logic              pready;
    logic              pslverr;
    logic [DATA_W-1:0] prdata;
  } smia_apb_rsp_s;

  // Device interrupt source levels
  typedef struct packed {
    logic parallelIrq;
    logic serialTwoIrq;
    logic serialOneIrq;
    logic floppyIrq;
    logic midiIrq;
    logic watchdogIrq;
    logic mouseIrq;
    logic keyboardIrq;
    logic kbdPortLine;
  } smia_dev_src_s;

endpackage

`default_nettype wire

// >>> tb/smia_agg_properties.sv
// Checker: port-level properties of the SMI aggregator
`timescale 1ns/10ps
`default_nettype none
module smia_agg_properties
(
  // Clock and reset
  input wire logic                    ref_clk,
  input wire logic                    rst_b,
  // Bus and device sources
  input wire smia_pkg::smia_apb_req_s apbReq,
  input wire smia_pkg::smia_apb_rsp_s apbRsp,
  input wire smia_pkg::smia_dev_src_s devSrc,
  // Group outputs
  input wire logic                    groupMgmtInterrupt,
  input wire logic                    mgmtInterruptOutN,
  input wire logic                    groupToSerialIrq,
  input wire logic                    groupToWakeLogic
);
  import smia_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  // Access-phase decodes
  wire [7:0] pa = apbReq.paddr;
  wire [7:0] rd = apbRsp.prdata[7:0];
  wire acc = apbReq.psel && apbReq.penable;
  wire rdAcc = acc && !apbReq.pwrite;
  wire bad = pa[1:0] != 2'b00 || pa < 8'h40 || pa > 8'h6C;
  // Route bits as last written over the bus to the second enable
  logic [2:0] routeMirror_reg;
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      routeMirror_reg <= 3'b000;
    end
    else if (acc && apbReq.pwrite && pa == 8'h5C)
    begin
      routeMirror_reg <= apbReq.pwdata[7:5];
    end
  end
  a_route_pin:
    assert property (mgmtInterruptOutN
      == !(groupMgmtInterrupt && routeMirror_reg[2]))
    else $error("pin level differs from group and route");
  a_route_sirq:
    assert property (groupToSerialIrq
      == (groupMgmtInterrupt && routeMirror_reg[1]))
    else $error("serial slot differs from group and route");
  a_route_wake:
    assert property (groupToWakeLogic
      == (groupMgmtInterrupt && routeMirror_reg[0]))
    else $error("wake route differs from group and route");
  a_read_upper_zero:
    assert property (rdAcc |-> apbRsp.prdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  a_gap_reads_zero:
    assert property (rdAcc && (pa == 8'h54 || pa == 8'h6C) |-> rd == 8'h00)
    else $error("gap read not zero");
  a_bad_addr_err:
    assert property (acc && bad |-> apbRsp.pslverr)
    else $error("unmapped access without error");
  a_dev_status_mirror:
    assert property ($stable(devSrc)[*6] ##0 (rdAcc && pa == 8'h40) |->
      rd == {devSrc.watchdogIrq, 1'b0, devSrc.midiIrq, devSrc.floppyIrq,
      devSrc.serialOneIrq, devSrc.serialTwoIrq, devSrc.parallelIrq, 1'b0})
    else $error("first status differs from sources");
  a_kbd_mirror:
    assert property ($stable(devSrc)[*6] ##0 (rdAcc && pa == 8'h44) |->
      {rd[4], rd[1:0]} == {devSrc.kbdPortLine, devSrc.keyboardIrq,
      devSrc.mouseIrq})
    else $error("second status differs from sources");
  a_reset_idle:
    assert property ($rose(rst_b) |-> !groupMgmtInterrupt && mgmtInterruptOutN)
    else $error("group active after reset");
  // Main scenarios reached
  cover property (groupToWakeLogic && groupToSerialIrq);
  cover property (!mgmtInterruptOutN);
  cover property (acc && bad);
endmodule
bind smia_aggregator smia_agg_properties smia_agg_properties_i (.ref_clk,
  .rst_b, .apbReq, .apbRsp, .devSrc, .groupMgmtInterrupt, .mgmtInterruptOutN,
  .groupToSerialIrq, .groupToWakeLogic);
`default_nettype wire

// >>> tb/smia_aggregator_tb.sv
// Testbench: register access, latching and routing of the aggregator
`timescale 1ns/10ps
`default_nettype none
module smia_aggregator_tb;
  import smia_pkg::*;
  logic          ref_clk, rst_b, infraredRx, grp, outN, sirq, wake;
  logic          pinSeen, slotSeen, err;
  logic [7:0]    pinA, pinB, pinFan;
  logic [31:0]   rd;
  smia_apb_req_s req;
  smia_apb_rsp_s rsp;
  smia_dev_src_s devSrc;
  int            miscompares = 0, checked = 0, cyc = 0;
  smia_aggregator smia_aggregator_i (.ref_clk, .rst_b, .apbReq(req),
    .apbRsp(rsp), .devSrc, .infraredRx, .pinEventsA(pinA),
    .pinEventsB(pinB), .pinEventsFan(pinFan), .groupMgmtInterrupt(grp),
    .mgmtInterruptOutN(outN), .groupToSerialIrq(sirq),
    .groupToWakeLogic(wake));
  smia_host_model smia_host_model_i (.ref_clk, .rst_b, .smiPinN(outN),
    .serialIrqSlot(sirq), .pinSeen, .slotSeen);
  // Clock
  initial
  begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  // Hang guard
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      miscompares++;
      tally_and_finish;
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One APB transfer, index given
  task automatic apb(input logic w, input logic [7:0] idx,
                     input logic [31:0] wd);
    @(posedge ref_clk);
    req <= '{1'b1, 1'b0, w, {idx[5:0], 2'b00}, wd};
    @(posedge ref_clk);
    req.penable <= 1'b1;
    @(posedge ref_clk);
    while (rsp.pready !== 1'b1) @(posedge ref_clk);
    rd = rsp.prdata;
    err = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 32'h0);
    chk(rd, {24'h0, exp});
  endtask
  task automatic settle;
    repeat (6) @(posedge ref_clk);
  endtask
  task automatic t_reset_values;
    for (int i = 16; i <= 27; i++) rdchk(i[7:0], 8'h00);
    $display("reset values done");
  endtask
  task automatic t_enables;
    for (int i = 22; i <= 27; i++) apb(1'b1, i[7:0], 32'hFF);
    apb(1'b1, 8'h15, 32'hFF);
    rdchk(8'h15, 8'h00);
    rdchk(8'h16, 8'hBE);
    rdchk(8'h17, 8'hF7);
    rdchk(8'h18, 8'hF7);
    rdchk(8'h19, 8'hFF);
    rdchk(8'h1A, 8'hCF);
    rdchk(8'h1B, 8'h00);
    apb(1'b0, 8'h30, 32'h0);
    chk(err, 1'b1);
    for (int i = 22; i <= 26; i++) apb(1'b1, i[7:0], 32'h0);
    $display("enables done");
  endtask
  task automatic t_pins;
    pinA <= 8'hFF;
    pinB <= 8'hFF;
    pinFan <= 8'hFF;
    settle;
    rdchk(8'h12, 8'hF7);
    rdchk(8'h13, 8'hFF);
    rdchk(8'h14, 8'hCF);
    chk({grp, outN}, 2'b01);
    apb(1'b1, 8'h18, 32'h01);
    apb(1'b1, 8'h17, 32'hE0);
    settle;
    chk({grp, outN, sirq, wake}, 4'b1011);
    chk({pinSeen, slotSeen}, 2'b11);
    apb(1'b1, 8'h12, 32'h01);
    rdchk(8'h12, 8'hF6);
    chk(grp, 1'b0);
    apb(1'b1, 8'h19, 32'h80);
    @(posedge ref_clk);
    chk(grp, 1'b1);
    apb(1'b1, 8'h19, 32'h00);
    apb(1'b1, 8'h1A, 32'h40);
    apb(1'b1, 8'h17, 32'h40);
    @(posedge ref_clk);
    chk(grp, 1'b1);
    chk({outN, sirq, wake}, 3'b110);
    apb(1'b1, 8'h1A, 32'h00);
    apb(1'b1, 8'h13, 32'h0);
    rdchk(8'h13, 8'hFF);
    for (int i = 18; i <= 20; i++) apb(1'b1, i[7:0], 32'hFF);
    rdchk(8'h13, 8'h00);
    rdchk(8'h14, 8'h00);
    pinA <= 8'h00;
    pinB <= 8'h00;
    pinFan <= 8'h00;
    $display("pin events done");
  endtask
  task automatic t_infrared;
    apb(1'b1, 8'h17, 32'hE4);
    infraredRx <= ~infraredRx;
    settle;
    chk({grp, outN}, 2'b10);
    rdchk(8'h11, 8'h04);
    rdchk(8'h11, 8'h00);
    @(posedge ref_clk);
    chk(grp, 1'b0);
    infraredRx <= ~infraredRx;
    settle;
    rdchk(8'h11, 8'h04);
    $display("infrared done");
  endtask
  task automatic t_device;
    devSrc <= '1;
    settle;
    rdchk(8'h10, 8'hBE);
    apb(1'b1, 8'h11, 32'hFF);
    rdchk(8'h11, 8'h13);
    chk(grp, 1'b0);
    apb(1'b1, 8'h17, 32'h01);
    @(posedge ref_clk);
    chk(grp, 1'b1);
    apb(1'b1, 8'h17, 32'h00);
    apb(1'b1, 8'h16, 32'h80);
    @(posedge ref_clk);
    chk(grp, 1'b1);
    devSrc <= '0;
    settle;
    chk(grp, 1'b0);
    rdchk(8'h11, 8'h00);
    rst_b <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_b <= 1'b1;
    rdchk(8'h16, 8'h00);
    $display("device sources done");
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    rst_b = 1'b0;
    req = '0;
    devSrc = '0;
    infraredRx = 1'b0;
    pinA = 8'h00;
    pinB = 8'h00;
    pinFan = 8'h00;
    repeat (8) @(posedge ref_clk);
    rst_b <= 1'b1;
    t_reset_values;
    t_enables;
    t_pins;
    t_infrared;
    t_device;
    tally_and_finish;
  end
endmodule
`default_nettype wire

// >>> tb/smia_host_model.sv
// Host side: samples the SMI pin and serial slot
`timescale 1ns/10ps
`default_nettype none
module smia_host_model
(
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic rst_b,
  // Lines from the device
  input  wire logic smiPinN,
  input  wire logic serialIrqSlot,
  // What the host saw
  output logic      pinSeen,
  output logic      slotSeen
);
  // Sample both lines every rising clock edge
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pinSeen <= 1'b0;
      slotSeen <= 1'b0;
    end
    else
    begin
      pinSeen <= !smiPinN;
      slotSeen <= serialIrqSlot;
    end
  end
endmodule
`default_nettype wire
